//--- logic/rxsl_bb.sv
// receive interface gain slicer: baseband end of the data port
`timescale 1ns/10ps
module rxsl_bb (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// link to device
	rxsl_if.bb               lnk,
	// configuration requests
	input  wire logic        cfg_req,
	input  wire logic        cfg_timing,
	input  wire logic        cfg_source,
	input  wire logic        cfg_kind,
	input  wire logic [3:0]  cfg_gain,
	output logic             cfg_refused,
	input  wire logic        set_req,
	input  wire logic [3:0]  set_gain,
	// received samples
	output logic [21:0]      rx_sample,
	output logic [3:0]       rx_extra,
	output logic             rx_chg,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	// readback
	output logic [3:0]       rb_gain,
	output logic [20:0]      rb_rssi
);
	// ----------------------------------------
	// control toward the device
	// ----------------------------------------
	logic       wr_q;      // configuration pulse
	logic       tm_q;      // timing setting
	logic       src_q;     // source setting
	logic       kind_q;    // table kind
	logic [3:0] gain_q;    // configured code
	logic       set_q;     // running code pulse
	logic [3:0] sgain_q;   // running code
	logic       ref_q;     // last request refused
	logic       kind_now;  // kind that the device holds

	// full write only in idle, code kept to the legal window
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q   <= 1'b0;
			tm_q   <= rxsl_pkg::TIMING_FRAME;
			src_q  <= rxsl_pkg::SRC_INTERNAL;
			kind_q <= rxsl_pkg::KIND_CORR;
			gain_q <= rxsl_pkg::GAIN_0DB;
			ref_q  <= 1'b0;
		end else begin
			wr_q <= cfg_req && lnk.dev_idle; // RULE16
			if (cfg_req) ref_q <= !lnk.dev_idle;
			if (cfg_req && lnk.dev_idle) begin // RULE14 RULE15
				tm_q   <= cfg_timing;
				src_q  <= cfg_source;
				kind_q <= cfg_kind;
				gain_q <= rxsl_pkg::clamp_code(cfg_gain, rxsl_pkg::legal_window(cfg_kind,
					lnk.dev_wb, lnk.dev_quant)); // RULE5 RULE11 RULE12
			end
		end
	end

	assign kind_now = kind_q;

	// running code, clamped to one of the ten and the window
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			set_q   <= 1'b0;
			sgain_q <= rxsl_pkg::GAIN_0DB;
		end else begin
			set_q <= set_req;
			if (set_req) sgain_q <= rxsl_pkg::clamp_code(set_gain,
				rxsl_pkg::legal_window(kind_now, lnk.dev_wb, lnk.dev_quant)); // RULE17
		end
	end

	assign lnk.cfg_wr     = wr_q;
	assign lnk.cfg_timing = tm_q;
	assign lnk.cfg_source = src_q;
	assign lnk.cfg_kind   = kind_q;
	assign lnk.cfg_gain   = gain_q;
	assign lnk.set_wr     = set_q;
	assign lnk.set_gain   = sgain_q;
	assign cfg_refused    = ref_q;

	// ----------------------------------------
	// sample intake
	// ----------------------------------------
	logic [21:0] smp_q;   // sample field
	logic [3:0]  ext_q;   // extra field
	logic        chg_q;   // change indicator
	logic        v_q;     // holding a word

	assign lnk.word_ready = !v_q || rx_ready;

	// unpack one word per handshake
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			smp_q <= '0;
			ext_q <= '0;
			chg_q <= 1'b0;
			v_q   <= 1'b0;
		end else if (lnk.word_ready) begin
			v_q <= lnk.word_valid;
			if (lnk.word_valid) begin // RULE21
				smp_q <= lnk.word[rxsl_pkg::WORD_SMP_LSB +: rxsl_pkg::IN_W];
				ext_q <= lnk.word[rxsl_pkg::WORD_EXT_LSB +: rxsl_pkg::CODE_W];
				chg_q <= lnk.word[rxsl_pkg::WORD_CHG_BIT];
			end
		end
	end

	assign rx_sample = smp_q;
	assign rx_extra  = ext_q;
	assign rx_chg    = chg_q;
	assign rx_valid  = v_q;

	// readback registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rb_gain <= rxsl_pkg::GAIN_0DB;
			rb_rssi <= '0;
		end else begin
			rb_gain <= lnk.rd_gain; // RULE18
			rb_rssi <= lnk.rd_rssi; // RULE19
		end
	end
endmodule

//--- logic/rxsl_dev.sv
// receive interface gain slicer: device end of the data port
// ----------------------------------------
// Overview of operation
// RULE1 - correction table: small fine gain per index
// RULE2 - internal source: gain from pre-slicer power
// RULE3 - correction, narrowband quantized: 0 to 18 dB
// RULE4 - correction, wideband: gain held at 0 dB
// RULE5 - external correction code chosen within legal range
// RULE6 - compensation: digital gain follows analog attenuation
// RULE7 - output word sliced up by shift value
// RULE8 - one bit of shift is 6 dB
// RULE9 - auto gain keeps power plus 15 dB below full scale
// RULE10 - compensation: -36..+18 narrow, -36..0 wide
// RULE11 - external compensation code slices like auto
// RULE12 - code 0 is +18 dB, code 9 -36 dB
// RULE13 - timing 0 waits frame start, 1 immediate
// RULE14 - source 0 internal, 1 external with code
// RULE15 - table kind 0 correction, 1 compensation
// RULE16 - full configuration written only in idle state
// RULE17 - running gain code accepted within ten options
// RULE18 - scaled samples delivered, applied gain readable
// RULE19 - signal strength measurement readable
// RULE20 - round to 15 or 16 bits, else 22
// RULE21 - word holds change bit, sample, extra field
// RULE22 - positive gains saturate instead of wrapping
// RULE23 - deferred change lands on frame start with flag
// ----------------------------------------
`timescale 1ns/10ps
module rxsl_dev (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// link to baseband
	rxsl_if.dev              lnk,
	// receive samples from the decimation chain
	input  wire logic [21:0] smp_in,
	input  wire logic        smp_valid,
	output logic             smp_ready,
	input  wire logic        frame_start,
	// front-end state
	input  wire logic [7:0]  corr_mult,
	input  wire logic [2:0]  fe_atten,
	// operating state
	input  wire logic        post_cal_idle_state,
	input  wire logic        wideband,
	input  wire rxsl_pkg::rxsl_quant_t quant_mode,
	input  wire logic        extra_gain_sel
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// saturate a wide signed value to n bits, sign-extended to 26
	function automatic logic signed [25:0] sat(input logic signed [25:0] v, input int n);
		logic signed [25:0] hi;
		logic signed [25:0] lo;
		hi = (26'sd1 <<< (n - 1)) - 26'sd1;
		lo = -(26'sd1 <<< (n - 1));
		if (v > hi) return hi;
		if (v < lo) return lo;
		return v;
	endfunction

	// round-half-up arithmetic right shift
	function automatic logic signed [25:0] rshr(input logic signed [25:0] v, input int s);
		logic signed [25:0] r;
		r = v;
		if (s > 0) r = (v + (26'sd1 <<< (s - 1))) >>> s;
		return r;
	endfunction

	// position of the highest set bit
	function automatic logic [4:0] msb(input logic [20:0] v);
		logic [4:0] p;
		p = 5'h00;
		for (int i = 0; i < rxsl_pkg::MAG_W; i++) begin
			if (v[i]) p = 5'(i);
		end
		return p;
	endfunction

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	logic       timing_q;   // gain_update_timing_select
	logic       source_q;   // gain_source_select
	logic       kind_q;     // gain_table_kind
	logic [3:0] ext_code_q; // user gain code
	logic       quant;      // a quantizer is in use

	assign quant = (quant_mode != rxsl_pkg::RXSL_Q_NONE);

	// full write only in idle; running code only if one of ten
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timing_q   <= rxsl_pkg::TIMING_FRAME;
			source_q   <= rxsl_pkg::SRC_INTERNAL;
			kind_q     <= rxsl_pkg::KIND_CORR;
			ext_code_q <= rxsl_pkg::GAIN_0DB;
		end else if (lnk.cfg_wr && post_cal_idle_state) begin // RULE16 RULE14 RULE15
			timing_q   <= lnk.cfg_timing;
			source_q   <= lnk.cfg_source;
			kind_q     <= lnk.cfg_kind;
			if (lnk.cfg_gain <= rxsl_pkg::GAIN_M36) ext_code_q <= lnk.cfg_gain; // RULE12
		end else if (lnk.set_wr && lnk.set_gain <= rxsl_pkg::GAIN_M36) begin // RULE17
			ext_code_q <= lnk.set_gain;
		end
	end

	// ----------------------------------------
	// digital gain ahead of the slicer
	// ----------------------------------------
	logic signed [29:0] prod;   // correction product
	logic signed [25:0] dg_w;   // scaled sample, wide
	logic signed [21:0] dg;     // scaled sample, internal width

	// correction: fine multiply; compensation: undo analog attenuation
	always_comb begin
		prod = 30'(signed'(smp_in)) * 30'(signed'({1'b0, corr_mult}));
		if (kind_q == rxsl_pkg::KIND_CORR) begin
			dg_w = 26'(prod >>> rxsl_pkg::CORR_FRAC); // RULE1
		end else begin
			// shift in 30 bits, then pin to 26 so that sat never sees a wrapped value
			prod = 30'(signed'(smp_in)) <<< fe_atten; // RULE6
			dg_w = (prod[29:25] == {5{prod[25]}}) ? prod[25:0] : {prod[29], {25{!prod[29]}}};
		end
		dg = 22'(sat(dg_w, rxsl_pkg::IN_W));
	end

	// ----------------------------------------
	// power measurement just before the slicer
	// ----------------------------------------
	logic [20:0] mag;    // sample magnitude
	logic [20:0] avg_q;  // averaged magnitude
	logic        take;   // a sample is accepted

	assign mag  = dg[21] ? 21'(-dg) : dg[20:0];
	assign take = smp_valid && smp_ready;

	// leaky average of magnitude
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avg_q <= '0;
		end else if (take) begin // RULE2
			if (mag >= avg_q) avg_q <= avg_q + ((mag - avg_q) >> rxsl_pkg::AVG_SHIFT);
			else avg_q <= avg_q - ((avg_q - mag) >> rxsl_pkg::AVG_SHIFT);
		end
	end

	// ----------------------------------------
	// gain decision
	// ----------------------------------------
	logic [7:0] win;      // legal code window
	logic [4:0] top;      // highest set bit of the average
	logic [3:0] auto_c;   // automatic code
	logic [3:0] tgt;      // wanted code
	logic [3:0] new_c;    // code for this sample
	logic [3:0] gain_q;   // applied code

	assign win = rxsl_pkg::legal_window(kind_q, wideband, quant); // RULE3 RULE4 RULE10
	assign top = msb(avg_q);

	// smallest code that leaves the peak allowance below full scale
	always_comb begin
		auto_c = (top > rxsl_pkg::AUTO_OFS) ? 4'(top - rxsl_pkg::AUTO_OFS) : 4'h0; // RULE9
		if (top - rxsl_pkg::AUTO_OFS > 5'(rxsl_pkg::GAIN_M36) && top > rxsl_pkg::AUTO_OFS)
			auto_c = rxsl_pkg::GAIN_M36;
	end

	// source choice, clamped to the window; external code stands in for auto
	assign tgt = rxsl_pkg::clamp_code((source_q == rxsl_pkg::SRC_EXTERNAL) ? ext_code_q
		: auto_c, win); // RULE11 RULE5

	// deferred change waits for the frame's first sample
	assign new_c = (timing_q == rxsl_pkg::TIMING_NOW || frame_start) ? tgt : gain_q; // RULE13

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) gain_q <= rxsl_pkg::GAIN_0DB;
		else if (take) gain_q <= new_c; // RULE23
	end

	// ----------------------------------------
	// slicer and quantizer
	// ----------------------------------------
	logic signed [25:0] wide;   // sample with three bits of left room
	logic signed [25:0] sl;     // sliced, 16-bit rounded
	logic signed [25:0] res;    // final value: rounded and saturated, or plain dg without quantizer
	logic [31:0]        word_d; // packed word

	always_comb begin
		// code c shifts down c-3 bits: code 3 bits 15..0, 4 bits 16..1
		wide = 26'(signed'(dg)) <<< 3; // RULE7 RULE8
		sl   = sat(rshr(wide, int'(new_c)), rxsl_pkg::OUT_W); // RULE22
		case (quant_mode)
			rxsl_pkg::RXSL_Q_16: res = sl; // RULE20
			rxsl_pkg::RXSL_Q_15: res = sat(rshr(sl, 1), rxsl_pkg::NAR_W);
			default:             res = 26'(signed'(dg));
		endcase
		word_d = '0;
		word_d[rxsl_pkg::WORD_SMP_LSB +: rxsl_pkg::IN_W] = res[21:0]; // RULE21
		word_d[rxsl_pkg::WORD_CHG_BIT] = (new_c != gain_q);
		if (extra_gain_sel) word_d[rxsl_pkg::WORD_EXT_LSB +: rxsl_pkg::CODE_W] = new_c;
	end

	// ----------------------------------------
	// output stage and data port buffer
	// ----------------------------------------
	logic [31:0] word_q;   // registered word
	logic        wv_q;     // registered word valid
	logic        f_ready;  // buffer has room

	assign smp_ready = !wv_q || f_ready;

	// one register ahead of the buffer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
			wv_q   <= 1'b0;
		end else if (smp_ready) begin
			wv_q <= smp_valid;
			if (take) word_q <= word_d; // RULE18
		end
	end

	rxsl_fifo #(
		.W (rxsl_pkg::WORD_W),
		.D (rxsl_pkg::FIFO_D)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_data   (word_q),
		.in_valid  (wv_q),
		.in_ready  (f_ready),
		.out_data  (lnk.word),
		.out_valid (lnk.word_valid),
		.out_ready (lnk.word_ready)
	);

	// ----------------------------------------
	// readback
	// ----------------------------------------
	assign lnk.rd_gain   = gain_q; // RULE18
	assign lnk.rd_rssi   = avg_q;  // RULE19
	assign lnk.dev_idle  = post_cal_idle_state;
	assign lnk.dev_wb    = wideband;
	assign lnk.dev_quant = quant;
endmodule

//--- logic/rxsl_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
module rxsl_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// fill side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// drain side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];   // storage
	logic [AW:0]  wr_q;      // write pointer with wrap bit
	logic [AW:0]  rd_q;      // read pointer with wrap bit
	logic         push;      // word written
	logic         pop;       // word read

	// full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_q[AW-1:0]];

	// storage write
	always_ff @(posedge clock) begin
		if (push) mem[wr_q[AW-1:0]] <= in_data;
	end

	// pointers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
endmodule

//--- logic/rxsl_if.sv
// data port and gain control link between slicer and baseband
`timescale 1ns/10ps
interface rxsl_if;
	logic [31:0] word;        // sliced sample word
	logic        word_valid;  // word offered
	logic        word_ready;  // baseband takes word
	logic        cfg_wr;      // full configuration write pulse
	logic        cfg_timing;  // gain_update_timing_select
	logic        cfg_source;  // gain_source_select
	logic        cfg_kind;    // gain_table_kind
	logic [3:0]  cfg_gain;    // external gain code
	logic        set_wr;      // on-the-fly gain code pulse
	logic [3:0]  set_gain;    // on-the-fly gain code
	logic        dev_idle;    // post_cal_idle_state
	logic        dev_wb;      // wideband operation
	logic        dev_quant;   // a quantizer is in use
	logic [3:0]  rd_gain;     // applied gain code
	logic [20:0] rd_rssi;     // measured signal level

	modport dev (input word_ready, cfg_wr, cfg_timing, cfg_source, cfg_kind, cfg_gain,
		set_wr, set_gain, output word, word_valid, dev_idle, dev_wb, dev_quant,
		rd_gain, rd_rssi);
	modport bb (output word_ready, cfg_wr, cfg_timing, cfg_source, cfg_kind, cfg_gain,
		set_wr, set_gain, input word, word_valid, dev_idle, dev_wb, dev_quant,
		rd_gain, rd_rssi);
endinterface

//--- logic/rxsl_pkg.sv
// shared constants, encodings and helpers for the receive interface gain slicer
package rxsl_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int IN_W   = 22;               // internal receive sample width
	localparam int OUT_W  = 16;               // quantized data port width
	localparam int NAR_W  = 15;               // narrow quantizer width
	localparam int WORD_W = 32;               // data port word per component
	localparam int CODE_W = 4;                // interface gain code width
	localparam int MAG_W  = 21;               // sample magnitude width
	localparam int CORR_W = 8;                // correction multiplier width
	localparam int ATT_W  = 3;                // front-end attenuation, 6 dB units
	localparam int FIFO_D = 16;               // data port buffer depth

	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam int WORD_CHG_BIT = 31;         // gain change indicator
	localparam int WORD_EXT_LSB = 27;         // extra field: zeros or gain code
	localparam int WORD_SMP_LSB = 0;          // 22-bit sample field

	// ----------------------------------------
	// gain codes: code 0 is +18 dB, each step 6 dB less
	// ----------------------------------------
	localparam logic [3:0] GAIN_P18 = 4'h0;   // +18 dB, widest left shift
	localparam logic [3:0] GAIN_0DB = 4'h3;   // 0 dB, bits 15..0
	localparam logic [3:0] GAIN_M36 = 4'h9;   // -36 dB, last legal code
	localparam int         STEP_DB  = 6;      // one bit of shift
	localparam int         PAR_DB   = 15;     // assumed peak to average ratio
	localparam int         PAR_BITS = (PAR_DB + STEP_DB - 1) / STEP_DB;
	localparam logic [4:0] AUTO_OFS = 5'(OUT_W - 2 - PAR_BITS - 3); // msb to code offset

	// ----------------------------------------
	// settings and reset values
	// ----------------------------------------
	localparam logic       TIMING_FRAME = 1'b0; // defer to next frame start
	localparam logic       TIMING_NOW   = 1'b1; // apply at once
	localparam logic       SRC_INTERNAL = 1'b0; // automatic gain
	localparam logic       SRC_EXTERNAL = 1'b1; // user code
	localparam logic       KIND_CORR    = 1'b0; // correction table
	localparam logic       KIND_COMP    = 1'b1; // compensation table
	localparam logic [7:0] CORR_UNITY   = 8'h80; // correction multiplier 1.0
	localparam int         CORR_FRAC    = 7;     // fraction bits of multiplier
	localparam int         AVG_SHIFT    = 4;     // power average time constant

	typedef enum logic [1:0] {
		RXSL_Q_NONE = 2'b00, // full 22 bits, no quantizer
		RXSL_Q_16   = 2'b01, // 16-bit quantizer
		RXSL_Q_15   = 2'b10  // 15-bit quantizer
	} rxsl_quant_t;

	// ----------------------------------------
	// legal code window for table kind, bandwidth and quantizer
	// ----------------------------------------
	function automatic logic [7:0] legal_window(input logic kind, input logic wb,
			input logic quant);
		logic [3:0] lo;
		logic [3:0] hi;
		lo = GAIN_0DB;
		hi = GAIN_0DB;
		if (kind == KIND_COMP) begin
			lo = wb ? GAIN_0DB : GAIN_P18;
			hi = GAIN_M36;
		end else if (!wb && quant) begin
			lo = GAIN_P18;
		end
		return {hi, lo};
	endfunction

	// ----------------------------------------
	// clamp a code into its legal window
	// ----------------------------------------
	function automatic logic [3:0] clamp_code(input logic [3:0] code, input logic [7:0] win);
		logic [3:0] r;
		r = code;
		if (r < win[3:0]) r = win[3:0];
		if (r > win[7:4]) r = win[7:4];
		return r;
	endfunction

endpackage

//--- tb/rxsl_checker.sv
// concurrent checks on the link between the slicer device end and baseband end
`timescale 1ns/10ps
module rxsl_checker (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// data port
	input wire logic [31:0] word,
	input wire logic        word_valid,
	input wire logic        word_ready,
	// gain control
	input wire logic        cfg_wr,
	input wire logic        cfg_kind,
	input wire logic [3:0]  cfg_gain,
	input wire logic        set_wr,
	input wire logic [3:0]  set_gain,
	// device state
	input wire logic        dev_idle,
	input wire logic        dev_wb,
	input wire logic        dev_quant,
	input wire logic [3:0]  rd_gain
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// a running code write is a single strobe
	sequence s_set_pulse;
		set_wr ##1 !set_wr;
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_word_held: assert property (word_valid && !word_ready |=> word_valid && $stable(word))
		else $error("word moved while stalled");
	a_word_pad: assert property (word_valid |-> word[26:22] == 5'h00)
		else $error("word padding not zero");
	a_quant_sext: assert property (word_valid && dev_quant |->
		word[21:15] inside {7'h00, 7'h7f})
		else $error("quantized sample not sign extended");
	a_gain_legal: assert property (rd_gain <= rxsl_pkg::GAIN_M36)
		else $error("applied code beyond nine");
	a_set_code: assert property (set_wr |-> set_gain <= rxsl_pkg::GAIN_M36 ##0 s_set_pulse)
		else $error("bad running code strobe");
	a_cfg_idle: assert property (cfg_wr |-> $past(dev_idle) && cfg_gain <= 4'h9)
		else $error("configuration sent outside idle");
	a_corr_range: assert property (word_valid && !cfg_kind |-> word[30:27] <= 4'h3)
		else $error("correction code below 0 dB");
	a_wb_corr: assert property (word_valid && !cfg_kind && dev_wb |-> word[30:27] == 4'h3)
		else $error("wideband correction gain not 0 dB");
	a_comp_wb: assert property (word_valid && cfg_kind && dev_wb |-> word[30:27] >= 4'h3)
		else $error("wideband compensation gain above 0 dB");
endmodule

//--- tb/tb.sv
// self-checking bench: slicer device end and baseband end joined by the link
`timescale 1ns/10ps
module tb;
	// ----------------------------------------
	// clock, reset and stimulus
	// ----------------------------------------
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [21:0] smp_in = 22'h000000;
	logic        smp_valid = 1'b0;
	logic        smp_ready;
	logic        frame_start = 1'b0;
	logic [2:0]  fe_atten = 3'h0;
	logic [7:0]  corr_mult = 8'h90;
	rxsl_pkg::rxsl_quant_t quant_mode = rxsl_pkg::RXSL_Q_16;
	logic        idle_st = 1'b1;
	logic        wideband = 1'b0;
	logic        cfg_req = 1'b0;
	logic        cfg_timing = 1'b1;
	logic        cfg_source = 1'b1;
	logic        cfg_kind = 1'b1;
	logic [3:0]  cfg_gain = 4'h3;
	logic        cfg_refused;
	logic        set_req = 1'b0;
	logic [3:0]  set_gain = 4'h3;
	logic [21:0] rx_sample;
	logic [3:0]  rx_extra;
	logic        rx_chg;
	logic        rx_valid;
	logic        rx_ready = 1'b1;
	logic [3:0]  rb_gain;
	logic [20:0] rb_rssi;
	int          error_cnt = 0;
	int          checked = 0;

	always #5 clock = ~clock;

	rxsl_if lnk ();
	rxsl_dev i_rxsl_dev (.clock(clock), .rst_n(rst_n), .lnk(lnk.dev), .smp_in(smp_in),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .frame_start(frame_start),
		.corr_mult(corr_mult), .fe_atten(fe_atten), .post_cal_idle_state(idle_st),
		.wideband(wideband), .quant_mode(quant_mode), .extra_gain_sel(1'b1));
	rxsl_bb i_rxsl_bb (.clock(clock), .rst_n(rst_n), .lnk(lnk.bb), .cfg_req(cfg_req),
		.cfg_timing(cfg_timing), .cfg_source(cfg_source), .cfg_kind(cfg_kind),
		.cfg_gain(cfg_gain), .cfg_refused(cfg_refused), .set_req(set_req),
		.set_gain(set_gain), .rx_sample(rx_sample), .rx_extra(rx_extra), .rx_chg(rx_chg),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rb_gain(rb_gain), .rb_rssi(rb_rssi));
	rxsl_checker i_rxsl_checker (.clock(clock), .rst_n(rst_n), .word(lnk.word),
		.word_valid(lnk.word_valid), .word_ready(lnk.word_ready), .cfg_wr(lnk.cfg_wr),
		.cfg_kind(lnk.cfg_kind), .cfg_gain(lnk.cfg_gain), .set_wr(lnk.set_wr),
		.set_gain(lnk.set_gain), .dev_idle(lnk.dev_idle), .dev_wb(lnk.dev_wb),
		.dev_quant(lnk.dev_quant), .rd_gain(lnk.rd_gain));

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	// compare and count, report a mismatch at once
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// counts, verdict and end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// expected 16-bit slice: gain by eight, rounded shift by code, saturate
	function automatic logic [31:0] ex(input longint s, input int c);
		longint w;
		w = ((s <<< 3) + (c > 0 ? longint'(1) << (c - 1) : 0)) >>> c;
		if (w > 32767) w = 32767;
		if (w < -32768) w = -32768;
		return 32'(w[21:0]);
	endfunction

	// full configuration request from the baseband side
	task automatic cfg(input logic tm, input logic src, input logic knd, input logic [3:0] g);
		@(posedge clock);
		cfg_timing <= tm;
		cfg_source <= src;
		cfg_kind <= knd;
		cfg_gain <= g;
		cfg_req <= 1'b1;
		@(posedge clock);
		cfg_req <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// running gain code request
	task automatic setg(input logic [3:0] g);
		@(posedge clock);
		set_gain <= g;
		set_req <= 1'b1;
		@(posedge clock);
		set_req <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// one sample in, wait for its word at the baseband outputs
	task automatic snd(input logic [21:0] s, input logic fs);
		int n;
		n = 0;
		@(posedge clock);
		smp_in <= s;
		smp_valid <= 1'b1;
		frame_start <= fs;
		do begin
			@(negedge clock);
			n++;
		end while (smp_ready !== 1'b1 && n < 40);
		@(posedge clock);
		smp_valid <= 1'b0;
		frame_start <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (rx_valid !== 1'b1 && n < 80);
		if (n >= 80) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every code on a positive and a negative sample, then attenuation follow-up
	task automatic t_codes();
		logic [21:0] s;
		cfg(1'b1, 1'b1, 1'b1, 4'h3);
		for (int c = 0; c < 10; c++) begin
			setg(4'(c));
			for (int k = 0; k < 2; k++) begin
				s = k ? 22'h3fedcc : 22'h001234;
				snd(s, 1'b0);
				chk(32'(rx_sample), ex($signed(s), c));
				chk(32'(rx_extra), 32'(c));
				chk(32'(rb_gain), 32'(c));
			end
		end
		@(posedge clock);
		fe_atten <= 3'h1;
		setg(4'h3);
		snd(22'h001234, 1'b0);
		chk(32'(rx_sample), ex(64'h2468, 3));
		@(posedge clock);
		fe_atten <= 3'h0;
		$display("codes done");
	endtask

	// deferred change lands on the frame start with the change flag
	task automatic t_frame();
		cfg(1'b0, 1'b1, 1'b1, 4'h9);
		snd(22'h000100, 1'b1);
		setg(4'h1);
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h9);
		chk(32'(rx_chg), 32'h0);
		snd(22'h000100, 1'b1);
		chk(32'(rb_gain), 32'h1);
		chk(32'(rx_chg), 32'h1);
		$display("frame done");
	endtask

	// legal windows per table kind and bandwidth
	task automatic t_window();
		cfg(1'b1, 1'b1, 1'b0, 4'h5);
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h3);
		chk(32'(rx_sample), 32'h120);
		setg(4'h0);
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h0);
		@(posedge clock);
		wideband <= 1'b1;
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h3);
		cfg(1'b1, 1'b1, 1'b1, 4'h0);
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h3);
		setg(4'h9);
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h9);
		@(posedge clock);
		wideband <= 1'b0;
		$display("window done");
	endtask

	// full configuration refused while channels run
	task automatic t_refuse();
		@(posedge clock);
		idle_st <= 1'b0;
		cfg(1'b1, 1'b1, 1'b0, 4'h0);
		chk(32'(cfg_refused), 32'h1);
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain), 32'h9);
		@(posedge clock);
		idle_st <= 1'b1;
		$display("refuse done");
	endtask

	// fill the buffer with the baseband stalled, then drain it
	task automatic t_fill();
		int n;
		int m;
		m = 0;
		@(posedge clock);
		rx_ready <= 1'b0;
		smp_in <= 22'h000200;
		smp_valid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clock);
			if (smp_ready !== 1'b1) break;
		end
		if (n == 40) begin
			error_cnt++;
			give_verdict();
		end
		@(posedge clock);
		smp_valid <= 1'b0;
		rx_ready <= 1'b1;
		repeat (60) begin
			@(negedge clock);
			if (rx_valid === 1'b1) m++;
		end
		chk(32'(n > 16), 32'h1);
		chk(32'(m), 32'(n));
		$display("fill done");
	endtask

	// internal gain from a loud signal ends at the largest attenuation
	task automatic t_auto();
		cfg(1'b1, 1'b0, 1'b1, 4'h3);
		quant_mode <= rxsl_pkg::RXSL_Q_15;
		snd(22'h000100, 1'b0);
		chk(32'(rb_gain < 4'h9), 32'h1);
		repeat (120) snd(22'h1f0000, 1'b0);
		chk(32'(rb_gain), 32'h9);
		chk(32'(rx_sample), 32'h3e00);
		chk(32'(rb_rssi != 21'h0), 32'h1);
		@(posedge clock);
		quant_mode <= rxsl_pkg::RXSL_Q_NONE;
		snd(22'h1f0000, 1'b0);
		chk(32'(rx_sample), 32'h1f0000);
		$display("auto done");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_codes();
		t_frame();
		t_window();
		t_refuse();
		t_fill();
		t_auto();
		give_verdict();
	end
endmodule
